// ### dv/qfl_rival_master.sv
// Competing master that drives the slave-select input
`timescale 1ns/1ps
module qfl_rival_master (
	input  wire i_mclk,
	input  wire i_grab,
	output reg  o_ss_n
);
	// Pulled up while released, so idle reads high
	initial o_ss_n = 1'b1;
	always @(posedge i_mclk) o_ss_n <= !i_grab;
endmodule

// ### dv/qfl_status_bench.sv
// Self-checking bench for the FIFO-level and status block
`timescale 1ns/1ps
`define CK(n,e,s) begin tests_run++; if ((s) !== (e)) begin n_fail++; \
	$display("MISMATCH %s exp %h got %h", n, e, s); end end
module qfl_status_bench;
	localparam DEPTH = 8;
	localparam AW = 3;
	logic i_mclk, i_rst_n, i_psel, i_penable, i_pwrite, grab, err;
	logic i_transfer_active, i_master_mode;
	logic [11:0] i_paddr;
	logic [31:0] i_pwdata, rd;
	logic [AW:0] i_tx_count, i_rx_count;
	wire i_slave_sel_in_n, o_pready, o_pslverr, o_rx_full_cond, o_irq;
	wire [31:0] o_prdata;
	int n_fail, tests_run, k;
	// Row: tx count, rx count, busy, expected status
	logic [19:0] rows [5] = '{20'h00006, 20'h88119, 20'h3500a, 20'h0110f,
		20'h70002};
	qfl_status #(.DEPTH(DEPTH), .AW(AW)) qfl_status_inst (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_psel(i_psel),
		.i_penable(i_penable),
		.i_pwrite(i_pwrite),
		.i_paddr(i_paddr),
		.i_pwdata(i_pwdata),
		.o_pready(o_pready),
		.o_pslverr(o_pslverr),
		.o_prdata(o_prdata),
		.i_tx_count(i_tx_count),
		.i_rx_count(i_rx_count),
		.i_transfer_active(i_transfer_active),
		.i_master_mode(i_master_mode),
		.i_slave_sel_in_n(i_slave_sel_in_n),
		.o_rx_full_cond(o_rx_full_cond),
		.o_irq(o_irq)
	);
	qfl_rival_master qfl_rival_master_inst (.i_mclk(i_mclk), .i_grab(grab),
		.o_ss_n(i_slave_sel_in_n));
	initial begin
		i_mclk = 0;
		forever #2.5 i_mclk = ~i_mclk;
	end
	// ************************************************************
	// Bus tasks and verdict
	// ************************************************************
	task end_sim;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_psel <= 1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_mclk);
		i_penable <= 1;
		k = 0;
		do begin
			@(posedge i_mclk);
			k++;
		end while (o_pready !== 1'b1 && k < 20);
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 0;
		i_penable <= 0;
		if (o_pready !== 1'b1) begin
			n_fail++;
			end_sim;
		end
	endtask
	task collide;
		grab <= 1;
		@(posedge i_mclk);
		grab <= 0;
		repeat (2) @(posedge i_mclk);
	endtask
	initial begin
		{i_rst_n, i_psel, i_penable, i_pwrite, grab, i_transfer_active} = 0;
		{i_paddr, i_pwdata, i_tx_count, i_rx_count} = 0;
		i_master_mode = 1;
		repeat (6) @(posedge i_mclk);
		i_rst_n <= 1;
		apb(0, 12'h028, 0);
		`CK("status reset", 32'h6, rd)
		foreach (rows[i]) begin
			i_tx_count <= rows[i][19:16];
			i_rx_count <= rows[i][15:12];
			i_transfer_active <= rows[i][8];
			apb(0, 12'h028, 0);
			`CK("status tx", rows[i][2:0], rd[2:0])
			`CK("status rx", {24'h0, rows[i][7:3]}, rd[31:3])
			apb(0, 12'h020, 0);
			`CK("tx level", {28'h0, rows[i][19:16]}, rd)
			apb(0, 12'h024, 0);
			`CK("rx level", {28'h0, rows[i][15:12]}, rd)
		end
		// Over-range write must leave the old threshold
		apb(1, 12'h01c, 32'h5);
		apb(1, 12'h01c, 32'h9);
		apb(0, 12'h01c, 0);
		`CK("threshold", 32'h5, rd)
		// Row sweep left a stale rx-full event behind
		apb(1, 12'h040, 32'h3);
		apb(1, 12'h044, 32'h3);
		#1 `CK("irq idle", 1'b0, o_irq)
		i_rx_count <= 5;
		@(posedge i_mclk);
		#1 `CK("cond at thr", 1'b0, o_rx_full_cond)
		i_rx_count <= 6;
		repeat (2) @(posedge i_mclk);
		#1 `CK("cond above", 1'b1, o_rx_full_cond)
		`CK("irq rx full", 1'b1, o_irq)
		apb(1, 12'h040, 32'h1);
		apb(1, 12'h024, 32'h1);
		apb(1, 12'h028, 32'h0);
		apb(0, 12'h028, 0);
		`CK("ro status", 32'h0a, rd)
		`CK("irq cleared", 1'b0, o_irq)
		i_transfer_active <= 1;
		collide;
		apb(0, 12'h028, 0);
		`CK("collide set", 1'b1, rd[6])
		apb(0, 12'h028, 0);
		`CK("collide read clr", 1'b0, rd[6])
		apb(1, 12'h044, 32'h0);
		#1 `CK("irq masked", 1'b0, o_irq)
		apb(1, 12'h044, 32'h2);
		#1 `CK("irq unmasked", 1'b1, o_irq)
		apb(1, 12'h040, 32'h2);
		#1 `CK("irq w1c", 1'b0, o_irq)
		i_master_mode <= 0;
		collide;
		apb(0, 12'h028, 0);
		`CK("slave no collide", 1'b0, rd[6])
		apb(0, 12'h030, 0);
		`CK("unmapped err", 1'b1, err)
		// Mid-run reset with collision, mask and threshold all live
		i_master_mode <= 1;
		collide;
		i_rst_n <= 0;
		i_tx_count <= 0;
		i_rx_count <= 0;
		i_transfer_active <= 0;
		repeat (6) @(posedge i_mclk);
		i_rst_n <= 1;
		#1 `CK("irq after reset", 1'b0, o_irq)
		apb(0, 12'h028, 0);
		`CK("status re-reset", 32'h6, rd)
		apb(0, 12'h01c, 0);
		`CK("thr re-reset", 32'h0, rd)
		end_sim;
	end
endmodule

// ### dv/qfl_status_sva.sv
// Port-level assertions for the FIFO-level and status block
`timescale 1ns/1ps
module qfl_status_sva #(parameter DEPTH = 8, parameter AW = 3) (
	input wire        i_mclk, i_rst_n, i_psel, i_penable, i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata, o_prdata,
	input wire        o_pready, o_pslverr, o_rx_full_cond, o_irq,
	input wire [AW:0] i_tx_count, i_rx_count,
	input wire        i_transfer_active, i_master_mode, i_slave_sel_in_n
);
	// ************************************************************
	// Reads sampled in the access phase
	// ************************************************************
	wire rd = i_psel && i_penable && !i_pwrite;
	wire st = rd && i_paddr == 12'h028;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	a_busy_bit: assert property (st |->
		o_prdata[0] == $past(i_transfer_active)) else $error("busy bit");
	a_tx_space: assert property (st |->
		o_prdata[1] == ($past(i_tx_count) != DEPTH)) else $error("tx space");
	a_tx_drain: assert property (st |->
		o_prdata[2] == ($past(i_tx_count) == 0)) else $error("tx empty");
	a_rx_data: assert property (st |->
		o_prdata[3] == ($past(i_rx_count) != 0)) else $error("rx data");
	a_rx_sat: assert property (st |->
		o_prdata[4] == ($past(i_rx_count) == DEPTH)) else $error("rx full");
	a_status_reserved: assert property (st |->
		!o_prdata[5] && o_prdata[31:7] == 0) else $error("reserved");
	a_tx_level: assert property (rd && i_paddr == 12'h020 |->
		o_prdata[AW:0] == $past(i_tx_count)) else $error("tx level");
	a_rx_level: assert property (rd && i_paddr == 12'h024 |->
		o_prdata[AW:0] == $past(i_rx_count)) else $error("rx level");
	a_cond_empty: assert property (i_rx_count == 0 |->
		!o_rx_full_cond) else $error("full cond on empty");
	a_cond_full: assert property (i_rx_count == DEPTH |->
		o_rx_full_cond) else $error("full cond off when full");
	c_collide: cover property (st && o_prdata[6]);
	c_irq: cover property (o_irq);
	c_cond: cover property (o_rx_full_cond);
endmodule
bind qfl_status qfl_status_sva #(.DEPTH(DEPTH), .AW(AW)) qfl_status_sva_inst (
	.i_mclk(i_mclk),
	.i_rst_n(i_rst_n),
	.i_psel(i_psel),
	.i_penable(i_penable),
	.i_pwrite(i_pwrite),
	.i_paddr(i_paddr),
	.i_pwdata(i_pwdata),
	.o_prdata(o_prdata),
	.o_pready(o_pready),
	.o_pslverr(o_pslverr),
	.o_rx_full_cond(o_rx_full_cond),
	.o_irq(o_irq),
	.i_tx_count(i_tx_count),
	.i_rx_count(i_rx_count),
	.i_transfer_active(i_transfer_active),
	.i_master_mode(i_master_mode),
	.i_slave_sel_in_n(i_slave_sel_in_n)
);

// ### logic/qfl_status.v
// FIFO-level, receive threshold and status registers with APB slave
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "qfl_consts.vh"

module qfl_status #(
	parameter DEPTH = `QFL_DEPTH_DEF,
	parameter AW    = 3
) (
	// Clock and reset
	input  wire          i_mclk,
	input  wire          i_rst_n,
	// APB slave
	input  wire          i_psel,
	input  wire          i_penable,
	input  wire          i_pwrite,
	input  wire [11:0]   i_paddr,
	input  wire [31:0]   i_pwdata,
	output wire          o_pready,
	output wire          o_pslverr,
	output reg  [31:0]   o_prdata,
	// FIFO and shifter state
	input  wire [AW:0]   i_tx_count,
	input  wire [AW:0]   i_rx_count,
	input  wire          i_transfer_active,
	input  wire          i_master_mode,
	input  wire          i_slave_sel_in_n,
	// Interrupt condition and request
	output wire          o_rx_full_cond,
	output wire          o_irq
);

	// ************************************************************
	// Helpers
	// ************************************************************
	function [31:0] zext;
		input [AW:0] v;
		begin
			zext = 32'h0000_0000;
			zext[AW:0] = v;
		end
	endfunction

	wire        wr_en;
	wire        rd_en;
	wire        hit_thr;
	wire        hit_tx;
	wire        hit_rx;
	wire        hit_st;
	wire        hit_is;
	wire        hit_im;
	wire        mapped;
	wire [31:0] status_word;
	wire [AW:0] thr_wide;
	wire        collide_evt;

	reg  [AW-1:0] rx_thresh_field_reg;
	reg           collision_error_flag_reg;
	reg  [`QFL_IRQ_BITS-1:0] irq_status_reg;
	reg  [`QFL_IRQ_BITS-1:0] irq_mask_reg;
	reg           rx_full_d_reg;
	reg  [31:0]   rdata_next;

	// Single-cycle access phase; no wait states
	assign o_pready  = 1'b1;
	assign wr_en     = i_psel & i_penable & i_pwrite;
	assign rd_en     = i_psel & i_penable & ~i_pwrite;
	assign hit_thr   = (i_paddr == `QFL_RX_THRESHOLD_OFS);
	assign hit_tx    = (i_paddr == `QFL_TX_FILL_OFS);
	assign hit_rx    = (i_paddr == `QFL_RX_FILL_OFS);
	assign hit_st    = (i_paddr == `QFL_STATUS_OFS);
	assign hit_is    = (i_paddr == `QFL_IRQ_STATUS_OFS);
	assign hit_im    = (i_paddr == `QFL_IRQ_MASK_OFS);
	assign mapped    = hit_thr | hit_tx | hit_rx | hit_st | hit_is | hit_im;
	assign o_pslverr = i_psel & i_penable & ~mapped;

	// ************************************************************
	// Receive threshold
	// ************************************************************
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			rx_thresh_field_reg <= {AW{1'b0}};
		end else if (wr_en && hit_thr) begin
			// Value above depth leaves the field untouched
			if (i_pwdata <= DEPTH) begin
				rx_thresh_field_reg <= i_pwdata[AW-1:0];
			end
		end
	end

	assign thr_wide       = {1'b0, rx_thresh_field_reg};
	assign o_rx_full_cond = (i_rx_count >=
		thr_wide + {{AW{1'b0}}, 1'b1});

	// ************************************************************
	// Collision flag
	// ************************************************************
	assign collide_evt = i_master_mode & i_transfer_active &
		~i_slave_sel_in_n;

	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			collision_error_flag_reg <= 1'b0;
		end else if (collide_evt) begin
			// New collision beats a clearing read
			collision_error_flag_reg <= 1'b1;
		end else if (rd_en && hit_st) begin
			collision_error_flag_reg <= 1'b0;
		end
	end

	// ************************************************************
	// Status word
	// ************************************************************
	assign status_word = {25'h0000000,
		collision_error_flag_reg,
		1'b0,
		(i_rx_count == DEPTH),
		(i_rx_count != {(AW+1){1'b0}}),
		(i_tx_count == {(AW+1){1'b0}}),
		(i_tx_count != DEPTH),
		i_transfer_active};

	// ************************************************************
	// Interrupts
	// ************************************************************
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			rx_full_d_reg <= 1'b0;
			irq_status_reg <= {`QFL_IRQ_BITS{1'b0}};
			irq_mask_reg <= {`QFL_IRQ_BITS{1'b0}};
		end else begin
			rx_full_d_reg <= o_rx_full_cond;
			if (wr_en && hit_im) begin
				irq_mask_reg <= i_pwdata[`QFL_IRQ_BITS-1:0];
			end
			// Write-one clears, event set wins; tx-empty never here
			irq_status_reg[`QFL_IRQ_RX_FULL] <=
				(o_rx_full_cond & ~rx_full_d_reg) |
				(irq_status_reg[`QFL_IRQ_RX_FULL] &
				~(wr_en & hit_is & i_pwdata[`QFL_IRQ_RX_FULL]));
			irq_status_reg[`QFL_IRQ_COLLIDE] <= collide_evt |
				(irq_status_reg[`QFL_IRQ_COLLIDE] &
				~(wr_en & hit_is & i_pwdata[`QFL_IRQ_COLLIDE]));
		end
	end

	assign o_irq = |(irq_status_reg & irq_mask_reg);

	// ************************************************************
	// Read data
	// ************************************************************
	always @* begin
		rdata_next = 32'h0000_0000;
		if (hit_thr) begin
			rdata_next = zext({1'b0, rx_thresh_field_reg});
		end else if (hit_tx) begin
			rdata_next = zext(i_tx_count);
		end else if (hit_rx) begin
			rdata_next = zext(i_rx_count);
		end else if (hit_st) begin
			rdata_next = status_word;
		end else if (hit_is) begin
			rdata_next[`QFL_IRQ_BITS-1:0] = irq_status_reg;
		end else if (hit_im) begin
			rdata_next[`QFL_IRQ_BITS-1:0] = irq_mask_reg;
		end
	end

	// Read data registered at setup so it is valid in the access phase
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_prdata <= 32'h0000_0000;
		end else if (i_psel && !i_penable && !i_pwrite) begin
			o_prdata <= rdata_next;
		end
	end

endmodule

// ### shared/qfl_consts.vh
// Constants for the FIFO-level and status register block
// Operation
// - Threshold in low bits; writes above depth dropped, old value kept.
// - Rx-full condition while receive count >= threshold plus one.
// - Depth is a parameter 8 to 256; fields sized by address bits.
// - Transmit level register reports current transmit FIFO entries.
// - Receive level register reports current receive FIFO entries.
// - Status bit 0 is high while a serial transfer runs.
// - Status bit 1 is high while transmit FIFO has a free slot.
// - Status bit 2 high when transmit FIFO is empty; never interrupts.
// - Status bit 3 is high while receive FIFO holds any entry.
// - Status bit 4 is high when receive FIFO is completely full.
// - Master only: slave-select asserted mid-transfer sets status bit 6.
// - Status bit 6 clears when software reads the status register.
// - Status reads 0x00000006 after reset.
`ifndef QFL_CONSTS_VH
`define QFL_CONSTS_VH

// ************************************************************
// Register offsets
// ************************************************************
`define QFL_RX_THRESHOLD_OFS  12'h01c
`define QFL_TX_FILL_OFS       12'h020
`define QFL_RX_FILL_OFS       12'h024
`define QFL_STATUS_OFS        12'h028
`define QFL_IRQ_STATUS_OFS    12'h040
`define QFL_IRQ_MASK_OFS      12'h044

// ************************************************************
// Status bit positions
// ************************************************************
`define QFL_ST_BUSY       0
`define QFL_ST_TX_SPACE   1
`define QFL_ST_TX_DRAIN   2
`define QFL_ST_RX_DATA    3
`define QFL_ST_RX_SAT     4
`define QFL_ST_COLLIDE    6

// ************************************************************
// Interrupt event bit positions
// ************************************************************
`define QFL_IRQ_RX_FULL   0
`define QFL_IRQ_COLLIDE   1
`define QFL_IRQ_BITS      2

// ************************************************************
// Reset values
// ************************************************************
`define QFL_STATUS_RST    32'h0000_0006
`define QFL_DEPTH_DEF     8

`endif
